// File: verilog/kir_keypad_irq.sv
// Keypad interrupt unit: pin detection, latch and APB registers
`timescale 1ns/1ns
module kir_keypad_irq #(
    parameter int NPINS = kir_pkg::PIN_COUNT
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [kir_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System
    input wire logic break_active,
    input wire logic vector_ack,
    // Pins
    input wire logic [NPINS-1:0] key_input_pins,
    output logic [NPINS-1:0] pull_up_en,
    output logic [NPINS-1:0] pull_down_en,
    // Requests
    output logic key_irq_req,
    output logic irq
);
    localparam int PAD = 8 - NPINS;

    logic [NPINS-1:0] pins_s;
    logic [NPINS-1:0] en_q;
    logic [NPINS-1:0] pol_q;
    logic [NPINS-1:0] act;
    logic [NPINS-1:0] prev_q;
    logic mode_q;
    logic block_q;
    logic latch_q;
    logic latch_d;
    logic ack_seen_q;
    logic permit_q;
    logic [kir_pkg::EV_W-1:0] sts_q;
    logic [kir_pkg::EV_W-1:0] mask_q;
    logic setup;
    logic wr_fire;
    logic mapped;
    logic clr_ok;
    logic ack;
    logic any_act;
    logic held;
    logic rise;
    logic set;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // Pin input path

    kir_sync #(.W(NPINS)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(key_input_pins),
        .q(pins_s)
    );

    // Asserted level per pin, only for enabled pins
    assign act = ~(pins_s ^ pol_q) & en_q;
    assign any_act = |act;
    assign held = |(act & prev_q);
    assign rise = |(act & ~prev_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= '0;
        end else begin
            prev_q <= act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign setup = psel & ~penable;
    assign wr_fire = psel & penable & pready & pwrite;
    assign mapped = (paddr == kir_pkg::OFS_STATUS_CTRL) ||
        (paddr == kir_pkg::OFS_PIN_ENABLE) ||
        (paddr == kir_pkg::OFS_PIN_POLARITY) ||
        (paddr == kir_pkg::OFS_IRQ_STATUS) ||
        (paddr == kir_pkg::OFS_IRQ_MASK) ||
        (paddr == kir_pkg::OFS_BREAK_CTRL);

    // Status clears are refused in break unless permitted; a refused clear
    // is simply lost, software repeats it once break has ended
    assign clr_ok = ~break_active | permit_q;
    assign ack = clr_ok & (vector_ack | (wr_fire &&
        paddr == kir_pkg::OFS_STATUS_CTRL &&
        pwdata[kir_pkg::SC_CLEAR_BIT]));

    ////////////////////////////////////////////////////////////////////////
    // Interrupt latch

    always_comb begin
        if (mode_q) begin
            set = any_act;
        end else begin
            set = rise & ~held;
        end
    end

    always_comb begin
        latch_d = latch_q;
        if (set) begin
            latch_d = 1'b1;
        end else if (mode_q) begin
            if ((ack | ack_seen_q) && !any_act) begin
                latch_d = 1'b0;
            end
        end else if (ack) begin
            latch_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= kir_pkg::RST_BIT;
        end else begin
            latch_q <= latch_d;
        end
    end

    // Acknowledge seen while inputs still asserted, in either order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_seen_q <= kir_pkg::RST_BIT;
        end else if (!mode_q || !latch_d) begin
            ack_seen_q <= 1'b0;
        end else if (ack) begin
            ack_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_irq_req <= 1'b0;
        end else begin
            key_irq_req <= latch_d & ~block_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= kir_pkg::RST_BIT;
            block_q <= kir_pkg::RST_BIT;
        end else if (wr_fire && paddr == kir_pkg::OFS_STATUS_CTRL) begin
            mode_q <= pwdata[kir_pkg::SC_SENS_BIT];
            block_q <= pwdata[kir_pkg::SC_BLOCK_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= '0;
        end else if (wr_fire && paddr == kir_pkg::OFS_PIN_ENABLE) begin
            en_q <= pwdata[NPINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_q <= '0;
        end else if (wr_fire && paddr == kir_pkg::OFS_PIN_POLARITY) begin
            pol_q <= pwdata[NPINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            permit_q <= kir_pkg::RST_BIT;
        end else if (wr_fire && paddr == kir_pkg::OFS_BREAK_CTRL) begin
            permit_q <= pwdata[kir_pkg::BRK_PERMIT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= '0;
        end else if (wr_fire && paddr == kir_pkg::OFS_IRQ_MASK) begin
            mask_q <= pwdata[kir_pkg::EV_W-1:0];
        end
    end

    // Pulls follow enable and polarity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_up_en <= '0;
            pull_down_en <= '0;
        end else begin
            pull_up_en <= en_q & ~pol_q;
            pull_down_en <= en_q & pol_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events, set wins over a same-cycle clear

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= '0;
        end else begin
            for (int i = 0; i < kir_pkg::EV_W; i++) begin
                if (wr_fire && clr_ok && pwdata[i] &&
                    paddr == kir_pkg::OFS_IRQ_STATUS) begin
                    sts_q[i] <= 1'b0;
                end
            end
            if (set && !latch_q) begin
                sts_q[kir_pkg::EV_REQ_BIT] <= 1'b1;
            end
            if (setup && !mapped) begin
                sts_q[kir_pkg::EV_ERR_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sts_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, answer in the first access cycle

    always_comb begin
        rd_mux = kir_pkg::RST_WORD;
        case (paddr)
            kir_pkg::OFS_STATUS_CTRL: begin
                rd_mux[kir_pkg::SC_SENS_BIT] = mode_q;
                rd_mux[kir_pkg::SC_BLOCK_BIT] = block_q;
                rd_mux[kir_pkg::SC_FLAG_BIT] = latch_q;
            end
            kir_pkg::OFS_PIN_ENABLE: begin
                rd_mux[7:0] = {{PAD{1'b0}}, en_q};
            end
            kir_pkg::OFS_PIN_POLARITY: begin
                rd_mux[7:0] = {{PAD{1'b0}}, pol_q};
            end
            kir_pkg::OFS_IRQ_STATUS: begin
                rd_mux[kir_pkg::EV_W-1:0] = sts_q;
            end
            kir_pkg::OFS_IRQ_MASK: begin
                rd_mux[kir_pkg::EV_W-1:0] = mask_q;
            end
            kir_pkg::OFS_BREAK_CTRL: begin
                rd_mux[kir_pkg::BRK_PERMIT_BIT] = permit_q;
            end
            default: begin
                rd_mux = kir_pkg::RST_WORD;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= kir_pkg::RST_WORD;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= pwrite ? kir_pkg::RST_WORD : rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup_sc_rd;
        psel && !penable && !pwrite && paddr == kir_pkg::OFS_STATUS_CTRL;
    endsequence

    sequence s_setup_en_rd;
        psel && !penable && !pwrite && paddr == kir_pkg::OFS_PIN_ENABLE;
    endsequence

    a_flag_readback: assert property (
        s_setup_sc_rd ##1 pready |->
        prdata[kir_pkg::SC_FLAG_BIT] == $past(latch_q) &&
        !prdata[kir_pkg::SC_CLEAR_BIT])
        else $error("pending flag readback wrong");

    a_reserved_zero: assert property (
        s_setup_en_rd |=> pready && !prdata[kir_pkg::EN_RSV_BIT])
        else $error("reserved enable bit not zero");

    a_block_gates_req: assert property (
        key_irq_req |-> !$past(block_q) && latch_q)
        else $error("request passed while blocked");

    a_break_holds: assert property (
        break_active && !permit_q && latch_q && !mode_q |=> latch_q)
        else $error("latch cleared in protected break");

    a_break_clear: assert property (
        break_active && permit_q && vector_ack && !mode_q && !set
        |=> !latch_q)
        else $error("permitted break clear ignored");

    a_edge_masked: assert property (
        !mode_q && held && !latch_q |=> !latch_q)
        else $error("edge set while other input held");

    a_level_holds: assert property (
        mode_q && any_act |=> latch_q [*1] ##0 $past(any_act))
        else $error("level request dropped while asserted");

    a_disabled_quiet: assert property (
        en_q == '0 && !latch_q |=> !latch_q)
        else $error("disabled pins set the latch");

    a_pull_match: assert property (
        ##1 pull_up_en == ($past(en_q) & ~$past(pol_q)) &&
        pull_down_en == ($past(en_q) & $past(pol_q)))
        else $error("pull selection wrong");
endmodule // kir_keypad_irq

// File: verilog/kir_pkg.sv
// Constants shared by the keypad interrupt register block
// Overview of operation
// - With break clearing permitted, clears during break work and stay cleared
// - With break clearing not permitted, break-time accesses clear no status bits; an unmapped access still sets the error event bit
// - A pending clear is held off during break; repeating it afterwards clears
// - Each pin selectable as source with own polarity; enabling turns on pull
// - Pending flag is read-only: 1 while a request is pending, else 0
// - Writing 1 to request clear drops the request; the bit reads 0
// - Block bit at 1 stops the latch from raising the request
// - Sensitivity bit: 1 selects edge and level, 0 edge only
// - Per-pin enable bits: 1 lets the pin set the latch, 0 ignores it
// - Reserved enable-register bit reads 0; software writes it only as 0
// - Polarity bit 1 means high or rising, 0 means low or falling
// - Latch sets when any enabled input reaches its asserted state
// - Edge mode: no set while another enabled input is already asserted
// - Level mode: clears only after all inputs idle and an acknowledge
// - Low or falling pins get a pullup, high or rising a pulldown
package kir_pkg;
    localparam int PIN_COUNT = 6;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PIN_ENABLE = 8'h04;
    localparam logic [7:0] OFS_PIN_POLARITY = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_BREAK_CTRL = 8'h14;
    // key_status_control fields
    localparam int SC_SENS_BIT = 0;
    localparam int SC_BLOCK_BIT = 1;
    localparam int SC_CLEAR_BIT = 2;
    localparam int SC_FLAG_BIT = 3;
    // key_pin_enable reserved bit
    localparam int EN_RSV_BIT = 6;
    // Sticky event fields
    localparam int EV_REQ_BIT = 0;
    localparam int EV_ERR_BIT = 1;
    localparam int EV_W = 2;
    // break_flag_control_reg field
    localparam int BRK_PERMIT_BIT = 0;
    // Reset values
    localparam logic RST_BIT = 1'b0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// File: verilog/kir_sync.sv
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/1ns
module kir_sync #(
    parameter int W = kir_pkg::PIN_COUNT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // kir_sync

// File: bench/kir_key_model.sv
// Keys on the keypad pins, with the block's pull devices
`timescale 1ns/1ns
module kir_key_model (
    // Clock
    input wire logic pclk,
    // Key commands
    input wire logic [5:0] drive,
    input wire logic [5:0] level,
    // Pull devices
    input wire logic [5:0] pull_up_en,
    input wire logic [5:0] pull_down_en,
    // Pins
    output logic [5:0] pins
);
    logic [5:0] float_q = 6'h15;
    // Unpulled open pins wander, so no settled value is assumed
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (drive[i]) pins[i] = level[i];
            else if (pull_up_en[i]) pins[i] = 1'b1;
            else if (pull_down_en[i]) pins[i] = 1'b0;
            else pins[i] = float_q[i];
        end
    end
endmodule // kir_key_model

// File: bench/test_keypad_interrupt_regs.sv
// Self-checking bench of the keypad interrupt register block
`timescale 1ns/1ns
module test_keypad_interrupt_regs;
    logic pclk, presetn, psel, penable, pwrite, brk, vack, pready, pslverr;
    logic key_irq_req, irq, serr, pol;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, e, p;
    logic [5:0] pu, pd, pins, drv, lvl;
    int err_total, check_count;
    kir_keypad_irq u_kir_keypad_irq (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .break_active(brk), .vector_ack(vack),
        .key_input_pins(pins), .pull_up_en(pu), .pull_down_en(pd),
        .key_irq_req(key_irq_req), .irq(irq));
    kir_key_model u_kir_key_model (.pclk(pclk), .drive(drv), .level(lvl),
        .pull_up_en(pu), .pull_down_en(pd), .pins(pins));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] scw(logic s, logic b, logic f);
        return {28'h0000000, f, 1'b0, b, s};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(pready, 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic key(input int i, input logic on, input logic lv);
        drv[i] <= on;
        lvl[i] <= lv;
        repeat (5) @(posedge pclk);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        err_total++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, brk, vack} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        drv = 6'h00;
        lvl = 6'h00;
        err_total = 0;
        check_count = 0;
        void'($urandom(66597));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 24; a += 4) rdchk(a[7:0], 32'h0);
        rdchk(8'h18, 32'h0);
        chk(serr, 1'b1);
        rdchk(8'h0C, 32'h2);
        apb(1'b1, 8'h0C, 32'h2);
        rdchk(8'h0C, 32'h0);
        $display("test reset and decode done");
        repeat (4) begin
            e = $urandom & 32'h3F;
            p = $urandom;
            apb(1'b1, 8'h04, e);
            apb(1'b1, 8'h08, p);
            rdchk(8'h04, e);
            rdchk(8'h08, p & 32'h3F);
            chk(pu, e[5:0] & ~p[5:0]);
            chk(pd, e[5:0] & p[5:0]);
        end
        $display("test registers and pulls done");
        apb(1'b1, 8'h10, 32'h1);
        for (int i = 0; i < 6; i++) begin
            pol = $urandom;
            apb(1'b1, 8'h08, {31'h0, pol} << i);
            apb(1'b1, 8'h04, 32'h1 << i);
            // Pull lags enable, so a false edge may come; clear it late
            repeat (4) @(posedge pclk);
            apb(1'b1, 8'h00, scw(1'b0, i[0], 1'b0) | 32'h4);
            apb(1'b1, 8'h0C, 32'h3);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0);
            key(i, 1'b1, pol);
            chk(key_irq_req, !i[0]);
            chk(irq, 1'b1);
            rdchk(8'h00, scw(1'b0, i[0], 1'b1));
            apb(1'b1, 8'h00, scw(1'b0, i[0], 1'b0) | 32'h4);
            rdchk(8'h00, scw(1'b0, i[0], 1'b0));
            key(i, 1'b0, pol);
            apb(1'b1, 8'h0C, 32'h1);
            // Irq trails the status register by one more edge
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0);
        end
        $display("test edge per pin done");
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h04, 32'h3);
        repeat (4) @(posedge pclk);
        apb(1'b1, 8'h00, 32'h4);
        key(0, 1'b1, 1'b0);
        apb(1'b1, 8'h00, 32'h4);
        key(1, 1'b1, 1'b0);
        rdchk(8'h00, 32'h0);
        key(0, 1'b0, 1'b0);
        key(1, 1'b0, 1'b0);
        $display("test edge blocking done");
        apb(1'b1, 8'h00, 32'h5);
        key(0, 1'b1, 1'b0);
        apb(1'b1, 8'h00, 32'h5);
        rdchk(8'h00, scw(1'b1, 1'b0, 1'b1));
        key(0, 1'b0, 1'b0);
        rdchk(8'h00, scw(1'b1, 1'b0, 1'b0));
        key(0, 1'b1, 1'b0);
        key(0, 1'b0, 1'b0);
        rdchk(8'h00, scw(1'b1, 1'b0, 1'b1));
        vack <= 1'b1;
        @(posedge pclk);
        vack <= 1'b0;
        repeat (3) @(posedge pclk);
        rdchk(8'h00, scw(1'b1, 1'b0, 1'b0));
        $display("test level mode done");
        apb(1'b1, 8'h00, 32'h0);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h14, k);
            key(0, 1'b1, 1'b0);
            key(0, 1'b0, 1'b0);
            brk <= 1'b1;
            apb(1'b1, 8'h00, 32'h4);
            rdchk(8'h00, scw(1'b0, 1'b0, k == 0));
            brk <= 1'b0;
            rdchk(8'h00, scw(1'b0, 1'b0, k == 0));
            apb(1'b1, 8'h00, 32'h4);
            rdchk(8'h00, 32'h0);
            // Same again, acknowledged by a vector fetch
            key(0, 1'b1, 1'b0);
            key(0, 1'b0, 1'b0);
            brk <= 1'b1;
            vack <= 1'b1;
            @(posedge pclk);
            vack <= 1'b0;
            rdchk(8'h00, scw(1'b0, 1'b0, k == 0));
            brk <= 1'b0;
            vack <= 1'b1;
            @(posedge pclk);
            vack <= 1'b0;
            rdchk(8'h00, 32'h0);
        end
        $display("test break gating done");
        complete_run();
    end
endmodule // test_keypad_interrupt_regs
